// ---- rcl_cfg_regs.sv ----
// Register bank for port link control and per-queue rate-code decoding.
`timescale 1ns/1ps
// What this block does
// R1: At 100BT, codes 1 to 99 limit to that many Mbps.
// R2: At 100BT, code 0 or 100 means full rate; reset 0.
// R3: Codes 101 to 115 give 64 to 960 Kbps in 64 Kbps steps.
// R4: At 10BT, codes 1 to 9 limit to that many Mbps.
// R5: At 10BT, code 0 or 10 means full rate; reset 0.
// R6: One code format serves all ingress and egress limit fields.
// R7: Control one bit 7 selects half duplex on port 3.
// R8: Control one bit 6 enables port 3 flow control.
// R9: Control one bit 5 runs port 3 at 10BT.
// R10: Control two bit 6 selects MAC role on port 3.
// R11: Register 0xff bit 6 inverts the port 4 transmit clock phase.
// R12: Software sets inversion only on the clock-mode side, back to back.
// R13: Reserved fields read fixed values and ignore writes.
// R14: Test registers are read-only fixed values 0x80 and 0x32.
// R15: Each queue is shaped to its decoded egress rate; this block only decodes the rate onto limit_rate_o.
// R16: Codes 116 to 127 mean no limiting.
module rcl_cfg_regs #(
  parameter int NUM_LIMITS = 4
) (
  input  wire logic                         mclk_i,
  input  wire logic                         rst_n_i,
  input  rcl_pkg::rcl_reg_req_type          req_i,
  output logic [7:0]                        rdata_o,
  output logic                              rvalid_o,
  input  wire logic [NUM_LIMITS-1:0]        limit_speed_10_i,
  input  wire logic [NUM_LIMITS*7-1:0]      limit_code_i,
  output rcl_pkg::rcl_rate_type [NUM_LIMITS-1:0] limit_rate_o,
  output rcl_pkg::rcl_link_cfg_type         link_cfg_o
);
  import rcl_pkg::*;

  // Offset decode flags; at most one is high for any address.
  logic       hit_test_a;
  logic       hit_test_b;
  logic       hit_p3_one;
  logic       hit_p3_two;
  logic       hit_p4_clock;
  logic       hit_any;
  logic       wr_p3_one;
  logic       wr_p3_two;
  logic       wr_p4_clock;
  logic       rd_strobe;
  // Writable control bits, one flip-flop each.
  logic       half_duplex_d;
  logic       half_duplex_q;
  logic       flow_ctrl_d;
  logic       flow_ctrl_q;
  logic       speed_10_d;
  logic       speed_10_q;
  logic       mac_role_d;
  logic       mac_role_q;
  logic       clk_invert_d;
  logic       clk_invert_q;
  logic [7:0] img_p3_one;
  logic [7:0] img_p3_two;
  logic [7:0] img_p4_clock;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic       rvalid_d;
  logic       rvalid_q;

  // A full byte compare keeps aliases out; only the five offsets decode, and any other read returns zero with rvalid.
  always_comb begin
    hit_test_a   = 1'b0;
    hit_test_b   = 1'b0;
    hit_p3_one   = 1'b0;
    hit_p3_two   = 1'b0;
    hit_p4_clock = 1'b0;
    case (req_i.addr)
      ADDR_TEST_A: begin
        hit_test_a = 1'b1;
      end
      ADDR_TEST_B: begin
        hit_test_b = 1'b1;
      end
      ADDR_P3_CTRL_1: begin
        hit_p3_one = 1'b1;
      end
      ADDR_P3_CTRL_2: begin
        hit_p3_two = 1'b1;
      end
      ADDR_P4_CLOCK: begin
        hit_p4_clock = 1'b1;
      end
      default: begin
      end
    endcase
    hit_any = hit_test_a | hit_test_b | hit_p3_one | hit_p3_two | hit_p4_clock;
  end

  // R14: the test offsets get no write strobe, so writes there are dropped.
  // Unmapped offsets raise no strobe either; a write there has no effect.
  always_comb begin
    wr_p3_one   = req_i.wr_en & hit_p3_one;
    wr_p3_two   = req_i.wr_en & hit_p3_two;
    wr_p4_clock = req_i.wr_en & hit_p4_clock;
    rd_strobe   = req_i.rd_en;
  end

  always_comb begin
    half_duplex_d = half_duplex_q;
    flow_ctrl_d   = flow_ctrl_q;
    speed_10_d    = speed_10_q;
    // R7 R8 R9: duplex, pause and speed bits of port 3.
    if (wr_p3_one) begin
      half_duplex_d = req_i.wdata[P3_HALF_DUPLEX_BIT];
      flow_ctrl_d   = req_i.wdata[P3_FLOW_CTRL_BIT];
      speed_10_d    = req_i.wdata[P3_SPEED_10_BIT];
    end
  end

  // All control bits clear on reset: full duplex, no pause, 100BT, PHY role.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      half_duplex_q <= 1'b0;
      flow_ctrl_q   <= 1'b0;
      speed_10_q    <= 1'b0;
    end else begin
      half_duplex_q <= half_duplex_d;
      flow_ctrl_q   <= flow_ctrl_d;
      speed_10_q    <= speed_10_d;
    end
  end

  always_comb begin
    mac_role_d = mac_role_q;
    // R10: MAC or PHY role.
    if (wr_p3_two) begin
      mac_role_d = req_i.wdata[P3_MAC_ROLE_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mac_role_q <= 1'b0;
    end else begin
      mac_role_q <= mac_role_d;
    end
  end

  always_comb begin
    clk_invert_d = clk_invert_q;
    // R11: clock phase inversion.
    if (wr_p4_clock) begin
      clk_invert_d = req_i.wdata[P4_CLK_INVERT_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      clk_invert_q <= 1'b0;
    end else begin
      clk_invert_q <= clk_invert_d;
    end
  end

  // R13: reserved fields come from constants, so writes never reach them.
  always_comb begin
    img_p3_one                      = {3'h0, P3_CTRL_1_RSVD};
    img_p3_one[P3_HALF_DUPLEX_BIT]  = half_duplex_q;
    img_p3_one[P3_FLOW_CTRL_BIT]    = flow_ctrl_q;
    img_p3_one[P3_SPEED_10_BIT]     = speed_10_q;
    img_p3_two                      = {2'h0, P3_CTRL_2_RSVD};
    img_p3_two[P3_MAC_ROLE_BIT]     = mac_role_q;
    img_p4_clock                    = 8'h00;
    img_p4_clock[P4_CLK_INVERT_BIT] = clk_invert_q;
  end

  // Reads use the stored bits, so a read beside a write sees the old value.
  // Read data fall back to zero between reads, so a stale byte never looks new.
  always_comb begin
    rdata_d  = 8'h00;
    rvalid_d = rd_strobe;
    // R14: fixed test values; unmapped offsets read as zero.
    if (rd_strobe && hit_any) begin
      if (hit_test_a) begin
        rdata_d = TEST_A_VALUE;
      end else if (hit_test_b) begin
        rdata_d = TEST_B_VALUE;
      end else if (hit_p3_one) begin
        rdata_d = img_p3_one;
      end else if (hit_p3_two) begin
        rdata_d = img_p3_two;
      end else begin
        rdata_d = img_p4_clock;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata_o                  = rdata_q;
  assign rvalid_o                 = rvalid_q;
  assign link_cfg_o.half_duplex   = half_duplex_q;
  assign link_cfg_o.flow_ctrl_en  = flow_ctrl_q;
  assign link_cfg_o.speed_10      = speed_10_q;
  assign link_cfg_o.mac_role      = mac_role_q;
  // R12: the phase flip is only meaningful on the clock-mode side.
  assign link_cfg_o.p4_clk_invert = clk_invert_q;

  // R6 R15: one decoder per limit field gives each queue its shaping rate.
  for (genvar g = 0; g < NUM_LIMITS; g++) begin : g_limit
    logic [6:0] field_code;
    assign field_code = limit_code_i[g*7 +: 7];
    rcl_rate_decode u_dec (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .speed_10_i (limit_speed_10_i[g]),
      .code_i     (field_code),
      .rate_o     (limit_rate_o[g])
    );
  end
endmodule // rcl_cfg_regs

// ---- rcl_pkg.sv ----
// Package with register map, field layout and rate codes for the rate-code and port-link configuration block.
package rcl_pkg;
  localparam logic [7:0] ADDR_TEST_A    = 8'hbf;
  localparam logic [7:0] ADDR_P3_CTRL_1 = 8'hcf;
  localparam logic [7:0] ADDR_P3_CTRL_2 = 8'hdf;
  localparam logic [7:0] ADDR_TEST_B    = 8'hef;
  localparam logic [7:0] ADDR_P4_CLOCK  = 8'hff;

  localparam logic [7:0] TEST_A_VALUE   = 8'h80;
  localparam logic [7:0] TEST_B_VALUE   = 8'h32;
  localparam logic [4:0] P3_CTRL_1_RSVD = 5'h15;
  localparam logic [5:0] P3_CTRL_2_RSVD = 6'h2c;

  localparam int P3_HALF_DUPLEX_BIT = 7;
  localparam int P3_FLOW_CTRL_BIT   = 6;
  localparam int P3_SPEED_10_BIT    = 5;
  localparam int P3_MAC_ROLE_BIT    = 6;
  localparam int P4_CLK_INVERT_BIT  = 6;

  localparam logic [6:0] CODE_FULL_RATE_100 = 7'h64;
  localparam logic [6:0] CODE_FULL_RATE_10  = 7'h0a;
  localparam logic [6:0] CODE_SUB_MBPS_LO   = 7'h65;
  localparam logic [6:0] CODE_SUB_MBPS_HI   = 7'h73;
  localparam logic [6:0] CODE_RESET         = 7'h00;
  localparam logic [16:0] KBPS_PER_MBPS     = 17'h003e8;
  localparam logic [16:0] KBPS_SUB_STEP     = 17'h00040;
  localparam logic [16:0] KBPS_LINE_100     = 17'h186a0;
  localparam logic [16:0] KBPS_LINE_10      = 17'h02710;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcl_reg_req_type;

  typedef struct packed {
    logic        limited;
    logic [16:0] rate_kbps;
  } rcl_rate_type;

  typedef struct packed {
    logic half_duplex;
    logic flow_ctrl_en;
    logic speed_10;
    logic mac_role;
    logic p4_clk_invert;
  } rcl_link_cfg_type;
endpackage : rcl_pkg

// ---- rcl_rate_decode.sv ----
// Decoder from a seven-bit rate-limit code to a target rate in kilobits per second.
`timescale 1ns/1ps
module rcl_rate_decode (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         speed_10_i,
  input  wire logic [6:0]   code_i,
  output rcl_pkg::rcl_rate_type rate_o
);
  import rcl_pkg::*;

  rcl_rate_type rate_d;
  rcl_rate_type rate_q;
  logic [6:0]   full_code;
  logic [16:0]  line_kbps;

  always_comb begin
    full_code = speed_10_i ? CODE_FULL_RATE_10 : CODE_FULL_RATE_100;
    line_kbps = speed_10_i ? KBPS_LINE_10 : KBPS_LINE_100;
    rate_d.limited   = 1'b0;
    rate_d.rate_kbps = line_kbps;
    // R2 R5: zero or the line code means no limiting.
    if (code_i == CODE_RESET || code_i == full_code) begin
      rate_d.limited = 1'b0;
    // R1 R4: whole megabits below line rate.
    end else if (code_i < full_code) begin
      rate_d.limited   = 1'b1;
      rate_d.rate_kbps = 17'(code_i * KBPS_PER_MBPS);
    // R3: 64 Kbps steps at both speeds.
    end else if (code_i >= CODE_SUB_MBPS_LO && code_i <= CODE_SUB_MBPS_HI) begin
      rate_d.limited   = 1'b1;
      rate_d.rate_kbps = 17'((code_i - CODE_SUB_MBPS_LO + 7'h01) * KBPS_SUB_STEP);
    end
    // R16: undefined codes fall through as unlimited.
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rate_q <= '0;
    end else begin
      rate_q <= rate_d;
    end
  end

  assign rate_o = rate_q;
endmodule // rcl_rate_decode

// ---- rcl_cfg_regs_sva.sv ----
// Assertion checker for the rate-code and port-link register bank.
`timescale 1ns/1ps
module rcl_cfg_regs_sva #(parameter int NUM_LIMITS = 4) (
  input wire logic                      mclk_i,
  input wire logic                      rst_n_i,
  input rcl_pkg::rcl_reg_req_type       req_i,
  input wire logic [7:0]                rdata_o,
  input wire logic                      rvalid_o,
  input wire logic [NUM_LIMITS-1:0]     limit_speed_10_i,
  input wire logic [NUM_LIMITS*7-1:0]   limit_code_i,
  input rcl_pkg::rcl_rate_type [NUM_LIMITS-1:0] limit_rate_o,
  input rcl_pkg::rcl_link_cfg_type      link_cfg_o
);
  import rcl_pkg::*;
  wire logic       rd = req_i.rd_en;
  wire logic       wr = req_i.wr_en;
  wire logic [7:0] ad = req_i.addr;
  wire logic [6:0] c0 = limit_code_i[6:0];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rvalid; rvalid_o == $past(rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("rvalid wrong");
  property p_test; rd && ad == ADDR_TEST_A |=> rdata_o == TEST_A_VALUE; endproperty
  a_test: assert property (p_test) else $error("test value wrong");
  property p_rsv; rd && ad == ADDR_P3_CTRL_1 |=> rdata_o[4:0] == P3_CTRL_1_RSVD; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits wrong");
  property p_ctl; wr && ad == ADDR_P3_CTRL_1 |=> link_cfg_o[4:2] == $past(req_i.wdata[7:5]); endproperty
  a_ctl: assert property (p_ctl) else $error("port 3 control wrong");
  property p_inv; wr && ad == ADDR_P4_CLOCK |=> link_cfg_o.p4_clk_invert == $past(req_i.wdata[6]); endproperty
  a_inv: assert property (p_inv) else $error("clock invert wrong");
  property p_hold; !wr |=> $stable(link_cfg_o); endproperty
  a_hold: assert property (p_hold) else $error("link config moved");
  property p_sub; c0 inside {[7'h65:7'h73]} |=> limit_rate_o[0] == {1'b1, (17'($past(c0)) - 17'h64) << 6}; endproperty
  a_sub: assert property (p_sub) else $error("sub rate wrong");
  property p_mbps; !limit_speed_10_i[0] && c0 inside {[7'h01:7'h63]} |=>
    limit_rate_o[0] == {1'b1, 17'($past(c0)) * 17'h3e8}; endproperty
  a_mbps: assert property (p_mbps) else $error("mbps rate wrong");
  property p_free; c0 > 7'h73 |=> !limit_rate_o[0].limited; endproperty
  a_free: assert property (p_free) else $error("undefined code limits");
  property p_role; wr && ad == ADDR_P3_CTRL_2 |=> link_cfg_o.mac_role == $past(req_i.wdata[6]); endproperty
  a_role: assert property (p_role) else $error("role select wrong");
  property p_full; c0 == 7'h00 || c0 == (limit_speed_10_i[0] ? 7'h0a : 7'h64) |=> !limit_rate_o[0].limited;
  endproperty
  a_full: assert property (p_full) else $error("full rate code limits");
  c_sub: cover property (c0 == 7'h73);
  c_rd: cover property (rd && ad == ADDR_P3_CTRL_1);
  c_wr: cover property (wr && ad == ADDR_P4_CLOCK);
endmodule // rcl_cfg_regs_sva

bind rcl_cfg_regs rcl_cfg_regs_sva #(.NUM_LIMITS(NUM_LIMITS)) u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .limit_speed_10_i(limit_speed_10_i),
  .limit_code_i(limit_code_i), .limit_rate_o(limit_rate_o), .link_cfg_o(link_cfg_o));

// ---- test_rcl_cfg_regs.sv ----
// Self-checking bench for the rate-code and port-link register bank.
`timescale 1ns/1ps
module test_rcl_cfg_regs;
  import rcl_pkg::*;
  logic             clk, rst_n, rv;
  logic [7:0]       rdat, w;
  logic [3:0]       spd;
  logic [27:0]      code;
  logic [6:0]       corn [12] = '{7'h00, 7'h01, 7'h09, 7'h0a, 7'h0b, 7'h63, 7'h64, 7'h65, 7'h72, 7'h73, 7'h74, 7'h7f};
  logic [7:0]       ads [6] = '{ADDR_TEST_A, ADDR_TEST_B, ADDR_P3_CTRL_1, ADDR_P3_CTRL_2, ADDR_P4_CLOCK, 8'h10};
  rcl_reg_req_type  req;
  rcl_rate_type [3:0] rate;
  rcl_link_cfg_type cfg;
  int               err_count, total_checks, cyc;
  rcl_cfg_regs #(.NUM_LIMITS(4)) dut_u (.mclk_i(clk), .rst_n_i(rst_n), .req_i(req), .rdata_o(rdat),
    .rvalid_o(rv), .limit_speed_10_i(spd), .limit_code_i(code), .limit_rate_o(rate), .link_cfg_o(cfg));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic rcl_rate_type exp_rate(logic s, logic [6:0] c);
    exp_rate = {1'b0, s ? 17'h02710 : 17'h186a0};
    if (c != 7'h00 && c < (s ? 7'h0a : 7'h64)) exp_rate = {1'b1, 17'(c) * 17'h003e8};
    else if (c > 7'h64 && c < 7'h74) exp_rate = {1'b1, (17'(c) - 17'h00064) * 17'h00040};
  endfunction
  task automatic chk(string nm, logic [17:0] seen, logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk) #1 req = {2'b01, a, 8'h00};
    chk("idle", {rv, rdat}, 18'h0);
    @(posedge clk) #1 req.rd_en = 1'b0;
    chk("read", {rv, rdat}, {1'b1, e});
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) #1 req = {2'b10, a, d};
    @(posedge clk) #1 req.wr_en = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    {req, spd, code, rst_n, w} = '0;
    void'($urandom(32'h4b8f));
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    // The first pass reads reset values; later passes read back what was written.
    for (int k = 0; k < 9; k++) begin
      chk("cfg", cfg, {w[7:5], w[6], w[6]});
      rd(ADDR_TEST_A, 8'h80);
      rd(ADDR_TEST_B, 8'h32);
      rd(ADDR_P3_CTRL_1, {w[7:5], 5'h15});
      rd(ADDR_P3_CTRL_2, {1'b0, w[6], 6'h2c});
      rd(ADDR_P4_CLOCK, {1'b0, w[6], 6'h00});
      rd(8'h10, 8'h00);
      w = k ? 8'($urandom) : 8'hff;
      for (int j = 0; j < 6; j++) wr(ads[j], w);
    end
    $display("register test done");
    for (int i = 0; i < 76; i++) begin
      @(posedge clk) #1 spd = i < 12 ? 4'ha : 4'($urandom);
      code = i < 12 ? {4{corn[i]}} : 28'($urandom);
      @(posedge clk) #1;
      for (int g = 0; g < 4; g++) chk("rate", rate[g], exp_rate(spd[g], code[g*7+:7]));
    end
    $display("decode test done");
    complete_run();
  end
endmodule // test_rcl_cfg_regs
